// ===== core/anps_regs.sv
// Expansion, next-page and master/slave status registers with read-clear and interrupt logic.
`default_nettype none

module anps_regs
  import anps_pkg::*;
#(
  parameter int IDLE_COUNT_WIDTH = 8
) (
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire logic [anps_pkg::ADDR_WIDTH-1:0] address,
  input  wire logic [anps_pkg::DATA_WIDTH-1:0] write_data,
  input  wire logic                         write_strobe,
  input  wire logic                         read_strobe,
  output var  logic [anps_pkg::DATA_WIDTH-1:0] read_data,
  input  wire anps_pkg::anps_line_type      line_status,
  input  wire anps_pkg::anps_event_type     line_event,
  input  wire anps_pkg::anps_page_type      partner_page,
  output var  anps_pkg::anps_page_type      transmit_page,
  output var  logic                         interrupt
);

  import anps_pkg::*;

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr,
                               input logic [ADDR_WIDTH-1:0] offset,
                               input logic                  strobe);
    hit = strobe && (addr == offset);
  endfunction : hit

  logic read_expansion;
  logic read_master_slave;
  logic write_transmit;
  logic write_event_clear;
  logic write_event_enable;

  assign read_expansion     = hit(address, OFFSET_NEGOTIATION_EXPANSION_STATUS, read_strobe);
  assign read_master_slave  = hit(address, OFFSET_MASTER_SLAVE_STATUS, read_strobe);
  assign write_transmit     = hit(address, OFFSET_NEXT_PAGE_TRANSMIT, write_strobe);
  assign write_event_clear  = hit(address, OFFSET_EVENT_CLEAR, write_strobe);
  assign write_event_enable = hit(address, OFFSET_EVENT_ENABLE, write_strobe);

  // ----------------------------------------------------------------------
  // Read-clear flags and idle error counter
  // ----------------------------------------------------------------------
  logic                        parallel_fault_flag;
  logic                        page_received_flag;
  logic                        ms_fault_flag;
  logic [IDLE_COUNT_WIDTH-1:0] idle_count;
  logic                        idle_saturated;

  anps_sticky_flag u_parallel_fault (
    .clock   (clock),
    .reset_n (reset_n),
    .set     (line_event.parallel_fault),
    .clear   (read_expansion),
    .flag    (parallel_fault_flag)
  );

  anps_sticky_flag u_page_received (
    .clock   (clock),
    .reset_n (reset_n),
    .set     (line_event.page_received),
    .clear   (read_expansion),
    .flag    (page_received_flag)
  );

  anps_sticky_flag u_ms_fault (
    .clock   (clock),
    .reset_n (reset_n),
    .set     (line_event.ms_fault),
    .clear   (read_master_slave),
    .flag    (ms_fault_flag)
  );

  // The count is sampled into the read data before the clear, so no error is lost.
  anps_sat_counter #(
    .WIDTH (IDLE_COUNT_WIDTH)
  ) u_idle_count (
    .clock     (clock),
    .reset_n   (reset_n),
    .increment (line_event.idle_error),
    .clear     (read_master_slave),
    .count     (idle_count),
    .saturated (idle_saturated)
  );

  // ----------------------------------------------------------------------
  // Sampled line status
  // ----------------------------------------------------------------------
  anps_line_type line_q;
  logic          partner_an_shown;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      line_q <= '0;
    end else begin
      line_q <= line_status;
    end
  end

  // Partner negotiation ability only means something while negotiation runs.
  assign partner_an_shown = line_q.autoneg_enable && line_q.partner_negotiation_capable;

  // ----------------------------------------------------------------------
  // Next-page registers
  // ----------------------------------------------------------------------
  anps_page_type received_page;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      transmit_page                 <= '0;
      transmit_page.page_code_field <= RESET_TX_CODE_FIELD;
    end else begin
      if (write_transmit) begin
        transmit_page.not_last            <= write_data[15];
        transmit_page.message_page_select <= write_data[13];
        transmit_page.message_comply_flag <= write_data[12];
        transmit_page.page_code_field     <= write_data[10:0];
      end
      // The toggle is hardware-owned: each sent word (page_sent pulse) flips it.
      if (line_event.page_sent) begin
        transmit_page.toggle <= ~transmit_page.toggle;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      received_page                 <= '0;
      received_page.page_code_field <= RESET_RX_CODE_FIELD;
    end else if (line_event.page_received) begin
      received_page          <= partner_page;
      received_page.reserved <= 1'b0;
      received_page.toggle   <= partner_page.toggle;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------------
  logic [EVENT_COUNT-1:0] event_pulse;
  logic [EVENT_COUNT-1:0] event_status;
  logic [EVENT_COUNT-1:0] event_enable;
  logic                   idle_saturated_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idle_saturated_q <= 1'b0;
    end else begin
      idle_saturated_q <= idle_saturated;
    end
  end

  assign event_pulse[EVENT_PARALLEL_FAULT] = line_event.parallel_fault;
  assign event_pulse[EVENT_PAGE_RECEIVED]  = line_event.page_received;
  assign event_pulse[EVENT_MS_FAULT]       = line_event.ms_fault;
  assign event_pulse[EVENT_IDLE_SATURATED] = idle_saturated && !idle_saturated_q;

  for (genvar i = 0; i < EVENT_COUNT; i++) begin : g_event
    anps_sticky_flag u_status (
      .clock   (clock),
      .reset_n (reset_n),
      .set     (event_pulse[i]),
      .clear   (write_event_clear && write_data[i]),
      .flag    (event_status[i])
    );
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      event_enable <= RESET_EVENT_ENABLE;
    end else if (write_event_enable) begin
      event_enable <= write_data[EVENT_COUNT-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      interrupt <= 1'b0;
    end else begin
      interrupt <= |(event_status & event_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [DATA_WIDTH-1:0] next_read_data;

  always_comb begin
    next_read_data = '0;
    case (address)
      OFFSET_NEGOTIATION_EXPANSION_STATUS: begin
        next_read_data[EXP_PARALLEL_FAULT_BIT] = parallel_fault_flag;
        next_read_data[EXP_PARTNER_NP_BIT]     = line_q.partner_next_page_able;
        next_read_data[EXP_LOCAL_NP_BIT]       = RESET_LOCAL_NEXT_PAGE_ABLE;
        next_read_data[EXP_PAGE_RECEIVED_BIT]  = page_received_flag;
        next_read_data[EXP_PARTNER_AN_BIT]     = partner_an_shown;
      end
      OFFSET_NEXT_PAGE_TRANSMIT: begin
        next_read_data          = transmit_page;
        next_read_data[14]      = 1'b0;
      end
      OFFSET_NEXT_PAGE_RECEIVED: begin
        next_read_data = received_page;
      end
      OFFSET_MASTER_SLAVE_STATUS: begin
        next_read_data[MS_FAULT_BIT]            = ms_fault_flag;
        next_read_data[MS_RESOLVED_MASTER_BIT]  = line_q.resolved_master;
        next_read_data[MS_LOCAL_RX_OK_BIT]      = line_q.local_rx_ok;
        next_read_data[MS_REMOTE_RX_OK_BIT]     = line_q.remote_rx_ok;
        next_read_data[MS_GIG_FULL_ADV_BIT]     = RESET_GIG_FULL_ADV;
        next_read_data[MS_PARTNER_GIG_HALF_BIT] = RESET_PARTNER_GIG_HALF;
        next_read_data[MS_IDLE_COUNT_MSB:0]     = idle_count[7:0];
      end
      OFFSET_EVENT_STATUS: begin
        next_read_data[EVENT_COUNT-1:0] = event_status;
      end
      OFFSET_EVENT_ENABLE: begin
        next_read_data[EVENT_COUNT-1:0] = event_enable;
      end
      default: begin
        next_read_data = '0;
      end
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= '0;
    end else if (read_strobe) begin
      read_data <= next_read_data;
    end else begin
      read_data <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_PDF_SET: assert property (
    line_event.parallel_fault |=> parallel_fault_flag)
    else $error("parallel fault flag not set");

  AST_PDF_READ_CLEAR: assert property (
    read_expansion && !line_event.parallel_fault |=> !parallel_fault_flag)
    else $error("parallel fault flag not cleared by read");

  AST_PAGE_READ_CLEAR: assert property (
    read_expansion && !line_event.page_received |=> !page_received_flag)
    else $error("page received flag not cleared by read");

  AST_PARTNER_NP: assert property (
    read_expansion |=> read_data[EXP_PARTNER_NP_BIT] == $past(line_status.partner_next_page_able, 2))
    else $error("partner next page bit wrong");

  AST_LOCAL_NP: assert property (
    read_expansion |=> read_data[EXP_LOCAL_NP_BIT])
    else $error("local next page bit not one");

  AST_PAGE_FLAG: assert property (
    line_event.page_received |=> page_received_flag ##0 received_page.page_code_field
      == $past(partner_page.page_code_field))
    else $error("page received flag or capture wrong");

  AST_PARTNER_AN: assert property (
    read_expansion |=> read_data[EXP_PARTNER_AN_BIT] ==
      ($past(line_status.autoneg_enable, 2) && $past(line_status.partner_negotiation_capable, 2)))
    else $error("partner negotiation bit wrong");

  AST_TX_WRITE: assert property (
    write_transmit |=> transmit_page.not_last == $past(write_data[15])
      && transmit_page.page_code_field == $past(write_data[10:0])
      && transmit_page.message_page_select == $past(write_data[13])
      && transmit_page.message_comply_flag == $past(write_data[12]))
    else $error("transmit page write not stored");

  AST_TOGGLE: assert property (
    line_event.page_sent |=> transmit_page.toggle != $past(transmit_page.toggle))
    else $error("transmit toggle did not invert");

  AST_RX_TOGGLE: assert property (
    line_event.page_received |=> received_page.toggle == $past(partner_page.toggle))
    else $error("received toggle not captured");

  AST_MS_FAULT: assert property (
    ms_fault_flag && read_master_slave |=> read_data[MS_FAULT_BIT])
    else $error("master slave fault not reported");

  AST_MS_READ_CLEAR: assert property (
    read_master_slave && !line_event.ms_fault |=> !ms_fault_flag)
    else $error("master slave fault not cleared by read");

  AST_MS_LEVELS: assert property (
    read_master_slave |=> read_data[14:10] == {$past(line_status.resolved_master, 2),
      $past(line_status.local_rx_ok, 2), $past(line_status.remote_rx_ok, 2), 2'b00})
    else $error("master slave status levels wrong");

  AST_IDLE_CLEAR: assert property (
    read_master_slave && !line_event.idle_error |=> idle_count == '0)
    else $error("idle count not restarted by read");

  AST_IDLE_SAT: assert property (
    idle_saturated && !read_master_slave |=> idle_saturated)
    else $error("idle count left saturation");

  AST_IRQ: assert property (
    |(event_status & event_enable) |=> interrupt)
    else $error("interrupt not raised");

  AST_READ_IDLE: assert property (
    !read_strobe |=> read_data == '0)
    else $error("read data not zero outside a read");

  COV_PAGE: cover property (line_event.page_received ##1 read_expansion);
  COV_SAT: cover property (idle_saturated);
  COV_IRQ: cover property ($rose(interrupt));
  COV_TOGGLE: cover property (line_event.page_sent ##[1:20] line_event.page_sent);

endmodule : anps_regs

`default_nettype wire

// ===== core/anps_pkg.sv
// Package for the auto-negotiation expansion, next-page and master/slave status registers.
`default_nettype none

package anps_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_WIDTH = 5;
  localparam int DATA_WIDTH = 16;

  localparam logic [4:0] OFFSET_NEGOTIATION_EXPANSION_STATUS = 5'h06;
  localparam logic [4:0] OFFSET_NEXT_PAGE_TRANSMIT           = 5'h07;
  localparam logic [4:0] OFFSET_NEXT_PAGE_RECEIVED           = 5'h08;
  localparam logic [4:0] OFFSET_MASTER_SLAVE_STATUS          = 5'h0a;
  localparam logic [4:0] OFFSET_EVENT_STATUS                 = 5'h12;
  localparam logic [4:0] OFFSET_EVENT_CLEAR                  = 5'h13;
  localparam logic [4:0] OFFSET_EVENT_ENABLE                 = 5'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EXP_PARALLEL_FAULT_BIT = 4;
  localparam int EXP_PARTNER_NP_BIT     = 3;
  localparam int EXP_LOCAL_NP_BIT       = 2;
  localparam int EXP_PAGE_RECEIVED_BIT  = 1;
  localparam int EXP_PARTNER_AN_BIT     = 0;

  localparam int MS_FAULT_BIT           = 15;
  localparam int MS_RESOLVED_MASTER_BIT = 14;
  localparam int MS_LOCAL_RX_OK_BIT     = 13;
  localparam int MS_REMOTE_RX_OK_BIT    = 12;
  localparam int MS_GIG_FULL_ADV_BIT    = 11;
  localparam int MS_PARTNER_GIG_HALF_BIT = 10;
  localparam int MS_IDLE_COUNT_MSB      = 7;

  // Event numbering inside the interrupt status, clear and enable registers.
  localparam int EVENT_COUNT           = 4;
  localparam int EVENT_PARALLEL_FAULT  = 0;
  localparam int EVENT_PAGE_RECEIVED   = 1;
  localparam int EVENT_MS_FAULT        = 2;
  localparam int EVENT_IDLE_SATURATED  = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic       RESET_LOCAL_NEXT_PAGE_ABLE = 1'b1;
  localparam logic [10:0] RESET_TX_CODE_FIELD       = 11'h001;
  localparam logic [10:0] RESET_RX_CODE_FIELD       = 11'h000;
  localparam logic       RESET_GIG_FULL_ADV         = 1'b0;
  localparam logic       RESET_PARTNER_GIG_HALF     = 1'b0;
  localparam logic [7:0] RESET_IDLE_COUNT           = 8'h00;
  localparam logic [3:0] RESET_EVENT_ENABLE         = 4'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // One next-page code word, in the layout of both next-page registers.
  typedef struct packed {
    logic        not_last;
    logic        reserved;
    logic        message_page_select;
    logic        message_comply_flag;
    logic        toggle;
    logic [10:0] page_code_field;
  } anps_page_type;

  // Levels reported by the line-side negotiation and receiver logic.
  typedef struct packed {
    logic autoneg_enable;
    logic partner_negotiation_capable;
    logic partner_next_page_able;
    logic resolved_master;
    logic local_rx_ok;
    logic remote_rx_ok;
  } anps_line_type;

  // One-cycle event pulses from the line-side logic.
  typedef struct packed {
    logic parallel_fault;
    logic page_received;
    logic page_sent;
    logic ms_fault;
    logic idle_error;
  } anps_event_type;

endpackage : anps_pkg

`default_nettype wire

// ===== core/anps_sticky_flag.sv
// Sticky flag that hardware sets and a clear strobe drops; set wins over clear.
`default_nettype none

module anps_sticky_flag (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  output var  logic flag
);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule : anps_sticky_flag

`default_nettype wire

// ===== core/anps_sat_counter.sv
// Saturating event counter that a clear strobe restarts; an event on the clear counts as one.
`default_nettype none

module anps_sat_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             increment,
  input  wire logic             clear,
  output var  logic [WIDTH-1:0] count,
  output var  logic             saturated
);

  localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (clear) begin
      count <= increment ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
    end else if (increment && count != MAX_COUNT) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign saturated = (count == MAX_COUNT);

endmodule : anps_sat_counter

`default_nettype wire

// ===== verif/anps_link_partner.sv
// Behavioural link partner that drives the line status, event pulses and received pages.
`default_nettype none

module anps_link_partner
  import anps_pkg::*;
(
  input  wire logic                     clock,
  output var  anps_pkg::anps_line_type  line_status,
  output var  anps_pkg::anps_event_type line_event,
  output var  anps_pkg::anps_page_type  partner_page
);
  timeunit 1ns;
  timeprecision 1ns;
  import anps_pkg::*;

  initial begin
    line_status  = '0;
    line_event   = '0;
    partner_page = '0;
  end

  // Levels from the negotiation and receiver logic change only after a clock edge.
  task automatic set_status(input anps_line_type status);
    @(posedge clock);
    line_status <= status;
  endtask : set_status

  // One-cycle event pulse; the page word is only meaningful beside the pulse, so it is
  // inverted afterwards to keep a stale word from passing for a fresh capture.
  task automatic pulse(input anps_event_type events, input anps_page_type page);
    @(posedge clock);
    line_event   <= events;
    partner_page <= page;
    @(posedge clock);
    line_event   <= '0;
    partner_page <= ~page;
  endtask : pulse

endmodule : anps_link_partner

`default_nettype wire

// ===== verif/anps_regs_tb.sv
// Self-checking testbench for the expansion, next-page and master/slave status registers.
`default_nettype none

module anps_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import anps_pkg::*;

  logic                    clock;
  logic                    reset_n;
  logic [ADDR_WIDTH-1:0]   address;
  logic [DATA_WIDTH-1:0]   write_data;
  logic                    write_strobe;
  logic                    read_strobe;
  logic [DATA_WIDTH-1:0]   read_data;
  anps_line_type           line_status;
  anps_event_type          line_event;
  anps_page_type           partner_page;
  anps_page_type           transmit_page;
  logic                    interrupt;
  int                      err_count;
  int                      checked;

  anps_regs dut_u (
    .clock         (clock),
    .reset_n       (reset_n),
    .address       (address),
    .write_data    (write_data),
    .write_strobe  (write_strobe),
    .read_strobe   (read_strobe),
    .read_data     (read_data),
    .line_status   (line_status),
    .line_event    (line_event),
    .partner_page  (partner_page),
    .transmit_page (transmit_page),
    .interrupt     (interrupt)
  );

  anps_link_partner partner_u (
    .clock        (clock),
    .line_status  (line_status),
    .line_event   (line_event),
    .partner_page (partner_page)
  );

  // ----------------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------------
  always #50 clock = ~clock;

  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [15:0] expected, input logic [15:0] seen);
    checked++;
    if (seen !== expected) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, expected, seen);
    end
  endtask : check

  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    @(posedge clock);
    address      <= addr;
    write_data   <= data;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : write_reg

  // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
  task automatic read_reg(input logic [4:0] addr, input logic [15:0] expected, input string name);
    @(posedge clock);
    address     <= addr;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    check(name, expected, read_data);
  endtask : read_reg

  task automatic check_irq(input logic expected);
    repeat (4) @(posedge clock);
    @(negedge clock);
    check("interrupt", {15'h0000, expected}, {15'h0000, interrupt});
  endtask : check_irq

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    address = '0;
    write_data = '0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    read_reg(5'h06, 16'h0004, "expansion reset");
    read_reg(5'h07, 16'h0001, "transmit reset");
    read_reg(5'h08, 16'h0000, "received reset");
    read_reg(5'h0a, 16'h0000, "master slave reset");
    read_reg(5'h1f, 16'h0000, "unmapped");
    read_reg(5'h14, 16'h0000, "event enable reset");
    partner_u.set_status(6'h3f);
    repeat (2) @(posedge clock);
    read_reg(5'h06, 16'h000d, "expansion levels");
    read_reg(5'h0a, 16'h7000, "master slave levels");
    // Negotiation disabled hides the partner ability even though it is still reported.
    partner_u.set_status(6'h1a);
    repeat (2) @(posedge clock);
    read_reg(5'h06, 16'h000c, "expansion disabled");
    read_reg(5'h0a, 16'h2000, "master slave slave");
    partner_u.pulse(5'h10, 16'h0000);
    read_reg(5'h06, 16'h001c, "parallel fault set");
    read_reg(5'h06, 16'h000c, "parallel fault cleared");
    partner_u.pulse(5'h08, 16'h7abc);
    read_reg(5'h06, 16'h000e, "page received set");
    read_reg(5'h08, 16'h3abc, "received page");
    read_reg(5'h06, 16'h000c, "page received cleared");
    write_reg(5'h07, 16'hffff);
    read_reg(5'h07, 16'hb7ff, "transmit all ones");
    partner_u.pulse(5'h04, 16'h0000);
    read_reg(5'h07, 16'hbfff, "transmit toggled");
    write_reg(5'h07, 16'h0000);
    read_reg(5'h07, 16'h0800, "transmit cleared");
    check("transmit_page", 16'h0800, transmit_page);
    write_reg(5'h08, 16'hffff);
    read_reg(5'h08, 16'h3abc, "received write ignored");
    partner_u.pulse(5'h02, 16'h0000);
    repeat (3) partner_u.pulse(5'h01, 16'h0000);
    read_reg(5'h0a, 16'ha003, "fault and idle count");
    read_reg(5'h0a, 16'h2000, "fault and count cleared");
    repeat (300) partner_u.pulse(5'h01, 16'h0000);
    read_reg(5'h0a, 16'h20ff, "idle count saturated");
    read_reg(5'h0a, 16'h2000, "saturated count cleared");
    write_reg(5'h13, 16'h000f);
    read_reg(5'h12, 16'h0000, "event status cleared");
    write_reg(5'h14, 16'h0002);
    read_reg(5'h14, 16'h0002, "event enable");
    partner_u.pulse(5'h10, 16'h0000);
    check_irq(1'b0);
    read_reg(5'h12, 16'h0001, "masked event status");
    partner_u.pulse(5'h08, 16'h0000);
    check_irq(1'b1);
    read_reg(5'h12, 16'h0003, "enabled event status");
    write_reg(5'h13, 16'h0002);
    check_irq(1'b0);
    read_reg(5'h12, 16'h0001, "event status after clear");
    // A reset in mid-run must bring back the code field and drop the toggle set above.
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    read_reg(5'h07, 16'h0001, "transmit after reset");
    check("transmit_page after reset", 16'h0001, transmit_page);
    report_and_stop();
  end

  // The sequence needs about 700 cycles; the watchdog allows more than twenty-five times that.
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    report_and_stop();
  end

endmodule : anps_regs_tb

`default_nettype wire
